// ---- thc_pkg.sv ----
/*
 Constants, types and helpers shared by the transmit HDLC controller, its checker and its testbench.
 Assumes a 250 MHz system clock and an APB master with 32-bit data.
*/
`default_nettype none
package thc_pkg;
	// Register indices; byte address is four times the index
	localparam logic [9:0] THC_IDX_CTRL1 = 10'h110;
	localparam logic [9:0] THC_IDX_SUPP = 10'h111;
	localparam logic [9:0] THC_IDX_CTRL2 = 10'h113;
	localparam logic [9:0] THC_IDX_FIFO = 10'h115;
	localparam logic [9:0] THC_IDX_AUX = 10'h116;
	localparam logic [9:0] THC_IDX_STAT = 10'h117;
	localparam logic [7:0] THC_CTRL1_RST = 8'h00;
	localparam logic [7:0] THC_SUPP_RST = 8'h00;
	localparam logic [7:0] THC_CTRL2_RST = 8'h00;
	localparam logic [7:0] THC_AUX_RST = 8'h00;
	// Control 1 fields
	localparam int THC_C1_FLAG_COUNT = 7;
	localparam int THC_C1_LOOP = 6;
	localparam int THC_C1_SRST = 5;
	localparam int THC_C1_MAP = 4;
	localparam int THC_C1_FILL = 3;
	localparam int THC_C1_EOM = 2;
	localparam int THC_C1_ZSD = 1;
	localparam int THC_C1_CRCD = 0;
	// Control 2 fields
	localparam int THC_C2_ABORT = 7;
	localparam int THC_C2_BOC = 6;
	localparam int THC_C2_EN = 5;
	localparam int THC_C2_CHAN_MSB = 4;
	// Auxiliary control fields
	localparam int THC_AUX_FDL_EN = 7;
	localparam int THC_AUX_T1 = 6;
	localparam int THC_AUX_CODE_MSB = 5;
	// Line bytes and CRC
	localparam logic [7:0] THC_FLAG = 8'h7e;
	localparam logic [7:0] THC_IDLE = 8'hff;
	localparam logic [7:0] THC_ABORT = 8'hfe;
	localparam logic [15:0] THC_CRC_POLY = 16'h8408;
	localparam logic [15:0] THC_CRC_INIT = 16'hffff;
	localparam logic [2:0] THC_STUFF_RUN = 3'h5;
	// Soft reset duration in cycles, far below the 250 us bound
	localparam logic [3:0] THC_SRST_CYCLES = 4'h8;
	localparam int THC_FIFO_DEPTH = 16;

	typedef enum logic [2:0] {S_FILL, S_FLAG, S_DATA, S_CRC_LO, S_CRC_HI, S_CLOSE, S_ABORT}
		thc_state_t;

	typedef struct packed {
		logic loop;
		logic eom;
		logic [7:0] data;
	} thc_entry_t;

	typedef struct packed {
		logic strobe;
		logic fdl;
		logic [4:0] chan;
		logic [2:0] pos;
	} thc_slot_t;

	function automatic logic [15:0] thc_crc_step(input logic [15:0] crc, input logic b);
		logic fb;
		fb = crc[0] ^ b;
		thc_crc_step = (crc >> 1) ^ (fb ? THC_CRC_POLY : 16'h0000);
	endfunction
endpackage
`default_nettype wire

// ---- thc_fifo.sv ----
/*
 Message FIFO with registered read data and a rewind mark for replaying a message.
 Assumes the reader pops at most once per cycle and never rewinds while flushing.
*/
`timescale 1ns/1ps
`default_nettype none
module thc_fifo #(
	parameter int W = 10,
	parameter int D = 16
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic flush_i,
	// Fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	// Drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o,
	// Replay control
	input wire logic commit_i,
	input wire logic rewind_i,
	output logic rewind_ok_o,
	output logic [$clog2(D):0] level_o
);
	localparam int AW = $clog2(D);
	localparam logic [AW:0] FULL = (AW+1)'(D);
	logic [W-1:0] mem [D];
	logic [AW:0] wr_q, rd_q, mark_q, rd_d;
	logic lost_q, valid_q;
	logic [W-1:0] data_q;
	wire logic push = in_valid_i & in_ready_o;
	wire logic pop = out_ready_i & out_valid_o;
	wire logic [AW:0] span = wr_q - mark_q;

	assign level_o = wr_q - rd_q;
	assign in_ready_o = level_o != FULL;
	assign out_valid_o = valid_q;
	assign out_data_o = data_q;
	assign rewind_ok_o = !lost_q;

	always_comb begin
		rd_d = rd_q;
		if (flush_i) begin
			rd_d = '0;
		end else if (rewind_i) begin
			rd_d = mark_q;
		end else if (pop) begin
			rd_d = rd_q + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_q[AW-1:0]] <= in_data_i;
		end
	end

	// Valid compares against the old write pointer so a fresh write is seen a cycle later
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wr_q <= '0;
			rd_q <= '0;
			mark_q <= '0;
			lost_q <= 1'b0;
			valid_q <= 1'b0;
			data_q <= '0;
		end else begin
			rd_q <= rd_d;
			valid_q <= !flush_i && (rd_d != wr_q);
			data_q <= mem[rd_d[AW-1:0]];
			if (flush_i) begin
				wr_q <= '0;
				mark_q <= '0;
				lost_q <= 1'b0;
			end else begin
				if (push) begin
					wr_q <= wr_q + 1'b1;
				end
				if (commit_i) begin
					mark_q <= rd_d;
					lost_q <= 1'b0;
				end else if (push && span >= FULL) begin
					lost_q <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ---- thc_top.sv ----
/*
 Transmit HDLC controller: APB registers, message FIFO, framing, stuffing, CRC,
 abort, looping and mapping of the bit stream into channel or FDL/Sa bit slots.
 Assumes the framer presents one slot descriptor per line bit opportunity.
*/
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - One or two flags between messages
// - Loop bit makes message repeat
// - Loop cleared: finish message, then flags
// - New message ends loop after flags
// - Two-byte CRC appended unless defeated
// - Soft reset flushes, then abort, fill
// - Soft reset bit clears itself quickly
// - Mapping select picks channel or FDL
// - Fill select chooses 7e or ff
// - End-of-message bit closes after byte
// - Zero after five ones unless defeated
// - Suppress bits exclude channel bit positions
// - Abort edge flushes, sends fe once
// - T1 only: send six-bit code
// - Controller runs only when enabled
// - Channel select applies at soft reset
module thc_top
	import thc_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Framer slot descriptor
	input wire thc_slot_t slot_i,
	// Line bit out
	output logic tx_bit_o,
	output logic tx_take_o
);
	logic [7:0] ctrl1_q, ctrl1_d, supp_q, ctrl2_q, aux_q;
	logic [4:0] chan_q;
	logic [3:0] srst_cnt_q;
	logic abort_prev_q;
	logic pready_q, pslverr_q;
	logic [31:0] prdata_q;
	logic [7:0] rd_mux;
	logic mapped, is_fifo;
	thc_state_t st_q, nst;
	logic [7:0] sh_q, nbyte;
	logic [2:0] bitcnt_q, ones_q;
	logic [15:0] crc_q;
	logic [7:0] crc_hi_q;
	logic cur_eom_q, cur_loop_q, neom, nloop;
	logic pop, commit, rewind;
	logic tx_bit_q, tx_take_q;
	logic [3:0] boc_cnt_q;
	logic f_in_ready, f_out_valid, f_rewind_ok;
	logic [4:0] f_level;
	thc_entry_t head;

	// Register bus decode
	wire logic [9:0] idx = paddr_i[11:2];
	wire logic access = psel_i & penable_i;
	wire logic done = access & pready_q;
	wire logic wr_go = done & pwrite_i & mapped;
	wire logic push = wr_go & is_fifo;
	wire logic wr_c1 = wr_go & (idx == THC_IDX_CTRL1);
	wire logic wr_supp = wr_go & (idx == THC_IDX_SUPP);
	wire logic wr_c2 = wr_go & (idx == THC_IDX_CTRL2);
	wire logic wr_aux = wr_go & (idx == THC_IDX_AUX);
	wire thc_entry_t push_entry = '{loop: ctrl1_q[THC_C1_LOOP], eom: ctrl1_q[THC_C1_EOM],
		data: pwdata_i[7:0]};
	wire logic [7:0] status = {st_q, f_level};

	always_comb begin
		rd_mux = 8'h00;
		mapped = 1'b1;
		is_fifo = 1'b0;
		if (idx == THC_IDX_CTRL1) begin
			rd_mux = ctrl1_q;
		end else if (idx == THC_IDX_SUPP) begin
			rd_mux = supp_q;
		end else if (idx == THC_IDX_CTRL2) begin
			rd_mux = ctrl2_q;
		end else if (idx == THC_IDX_FIFO) begin
			is_fifo = 1'b1;
		end else if (idx == THC_IDX_AUX) begin
			rd_mux = aux_q;
		end else if (idx == THC_IDX_STAT) begin
			rd_mux = status;
		end else begin
			mapped = 1'b0;
		end
	end

	// FIFO writes wait while the FIFO is full
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			pready_q <= access & !pready_q & (!(is_fifo & pwrite_i) | f_in_ready);
			if (access & !pready_q) begin
				prdata_q <= {24'h00_0000, rd_mux};
				pslverr_q <= !mapped;
			end
		end
	end

	// Soft reset and abort events
	wire logic srst_start = wr_c1 & pwdata_i[THC_C1_SRST];
	wire logic srst_busy = srst_cnt_q != 4'h0;
	wire logic abort_rise = ctrl2_q[THC_C2_ABORT] & !abort_prev_q;
	wire logic flush = srst_start | abort_rise;

	always_comb begin
		ctrl1_d = ctrl1_q;
		if (push) begin
			ctrl1_d[THC_C1_EOM] = 1'b0;
		end
		if (srst_cnt_q == 4'h1) begin
			ctrl1_d[THC_C1_SRST] = 1'b0;
		end
		if (wr_c1) begin
			ctrl1_d = pwdata_i[7:0];
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ctrl1_q <= THC_CTRL1_RST;
			supp_q <= THC_SUPP_RST;
			ctrl2_q <= THC_CTRL2_RST;
			aux_q <= THC_AUX_RST;
			chan_q <= 5'h00;
			srst_cnt_q <= 4'h0;
			abort_prev_q <= 1'b0;
		end else begin
			ctrl1_q <= ctrl1_d;
			abort_prev_q <= ctrl2_q[THC_C2_ABORT];
			if (wr_supp) begin
				supp_q <= pwdata_i[7:0];
			end
			if (wr_c2) begin
				ctrl2_q <= pwdata_i[7:0];
			end
			if (wr_aux) begin
				aux_q <= pwdata_i[7:0];
			end
			if (srst_start) begin
				chan_q <= ctrl2_q[THC_C2_CHAN_MSB:0];
			end
			if (srst_start) begin
				srst_cnt_q <= THC_SRST_CYCLES;
			end else if (srst_busy) begin
				srst_cnt_q <= srst_cnt_q - 4'h1;
			end
		end
	end

	// Slot mapping
	wire logic enabled = ctrl2_q[THC_C2_EN];
	wire logic t1_mode = aux_q[THC_AUX_T1];
	wire logic boc_take = slot_i.strobe & enabled & t1_mode & ctrl2_q[THC_C2_BOC] & slot_i.fdl;
	wire logic chan_hit = !ctrl1_q[THC_C1_MAP] & (slot_i.chan == chan_q) & !supp_q[slot_i.pos];
	wire logic fdl_hit = ctrl1_q[THC_C1_MAP] & aux_q[THC_AUX_FDL_EN] & slot_i.fdl;
	wire logic take = slot_i.strobe & enabled & !srst_busy & !boc_take & (chan_hit | fdl_hit);

	wire logic [15:0] boc_word = {8'hff, 1'b0, aux_q[THC_AUX_CODE_MSB:0], 1'b0};

	// Serializer
	wire logic stuffable = (st_q == S_DATA) | (st_q == S_CRC_LO) | (st_q == S_CRC_HI);
	wire logic stuff_now = ones_q == THC_STUFF_RUN;
	wire logic bit_out = stuff_now ? 1'b0 : sh_q[0];
	wire logic step = take & !stuff_now & (bitcnt_q == 3'h7);
	wire logic [15:0] crc_next = thc_crc_step(crc_q, sh_q[0]);
	wire logic [7:0] fill_byte = ctrl1_q[THC_C1_FILL] ? THC_IDLE : THC_FLAG;
	wire logic close_go = step & (nst == S_CLOSE) & (st_q != S_CLOSE);
	wire logic looping = cur_loop_q & ctrl1_q[THC_C1_LOOP] & !f_out_valid & f_rewind_ok;

	// Byte sequencer, evaluated at each byte boundary
	always_comb begin
		nst = st_q;
		nbyte = fill_byte;
		pop = 1'b0;
		neom = cur_eom_q;
		nloop = cur_loop_q;
		case (st_q)
			S_FILL, S_ABORT: begin
				if (f_out_valid) begin
					nst = S_FLAG;
					nbyte = THC_FLAG;
				end else begin
					nst = S_FILL;
				end
			end
			S_FLAG: begin
				if (f_out_valid) begin
					nst = S_DATA;
					nbyte = head.data;
					pop = 1'b1;
					neom = head.eom;
					nloop = head.loop;
				end else begin
					nst = S_FILL;
				end
			end
			S_DATA: begin
				if (cur_eom_q) begin
					if (ctrl1_q[THC_C1_CRCD]) begin
						nst = S_CLOSE;
						nbyte = THC_FLAG;
					end else begin
						nst = S_CRC_LO;
						nbyte = ~crc_next[7:0];
					end
				end else if (f_out_valid) begin
					nbyte = head.data;
					pop = 1'b1;
					neom = head.eom;
					nloop = head.loop;
				end else begin
					nst = S_ABORT;
					nbyte = THC_ABORT;
				end
			end
			S_CRC_LO: begin
				nst = S_CRC_HI;
				nbyte = crc_hi_q;
			end
			S_CRC_HI: begin
				nst = S_CLOSE;
				nbyte = THC_FLAG;
			end
			S_CLOSE: begin
				if (f_out_valid & ctrl1_q[THC_C1_FLAG_COUNT]) begin
					nst = S_FLAG;
					nbyte = THC_FLAG;
				end else if (f_out_valid) begin
					nst = S_DATA;
					nbyte = head.data;
					pop = 1'b1;
					neom = head.eom;
					nloop = head.loop;
				end else begin
					nst = S_FILL;
				end
			end
			default: begin
				nst = S_FILL;
			end
		endcase
	end

	assign rewind = close_go & looping;
	assign commit = (close_go & !looping) | (step & (nst == S_ABORT) & (st_q == S_DATA));

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_q <= S_FILL;
			sh_q <= THC_FLAG;
			bitcnt_q <= 3'h0;
			ones_q <= 3'h0;
			crc_q <= THC_CRC_INIT;
			crc_hi_q <= 8'h00;
			cur_eom_q <= 1'b0;
			cur_loop_q <= 1'b0;
		end else if (flush) begin
			st_q <= S_ABORT;
			sh_q <= THC_ABORT;
			bitcnt_q <= 3'h0;
			ones_q <= 3'h0;
			crc_q <= THC_CRC_INIT;
			cur_eom_q <= 1'b0;
			cur_loop_q <= 1'b0;
		end else if (take) begin
			if (stuff_now) begin
				ones_q <= 3'h0;
			end else begin
				ones_q <= (stuffable & sh_q[0] & !ctrl1_q[THC_C1_ZSD]) ? ones_q + 3'h1 : 3'h0;
				if (st_q == S_DATA) begin
					crc_q <= crc_next;
				end else begin
					crc_q <= THC_CRC_INIT;
				end
				if (bitcnt_q == 3'h7) begin
					st_q <= nst;
					sh_q <= nbyte;
					bitcnt_q <= 3'h0;
					cur_eom_q <= neom;
					cur_loop_q <= nloop;
					if (st_q == S_DATA) begin
						crc_hi_q <= ~crc_next[15:8];
					end
				end else begin
					sh_q <= {1'b0, sh_q[7:1]};
					bitcnt_q <= bitcnt_q + 3'h1;
				end
			end
		end
	end

	// Line outputs and code pattern
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tx_bit_q <= 1'b1;
			tx_take_q <= 1'b0;
			boc_cnt_q <= 4'h0;
		end else begin
			tx_take_q <= take | boc_take;
			if (boc_take) begin
				tx_bit_q <= boc_word[boc_cnt_q];
				boc_cnt_q <= boc_cnt_q + 4'h1;
			end else if (take) begin
				tx_bit_q <= bit_out;
			end
		end
	end

	thc_entry_t f_out_data_w;
	assign head = f_out_data_w;

	thc_fifo #(
		.W($bits(thc_entry_t)),
		.D(THC_FIFO_DEPTH)
	) u_fifo (
		.clk_i(sys_clk_i),
		.resetn_i(resetn_i),
		.flush_i(flush),
		.in_valid_i(push),
		.in_ready_o(f_in_ready),
		.in_data_i(push_entry),
		.out_valid_o(f_out_valid),
		.out_ready_i(step & pop),
		.out_data_o(f_out_data_w),
		.commit_i(commit),
		.rewind_i(rewind),
		.rewind_ok_o(f_rewind_ok),
		.level_o(f_level)
	);

	assign prdata_o = prdata_q;
	assign pready_o = pready_q;
	assign pslverr_o = pslverr_q;
	assign tx_bit_o = tx_bit_q;
	assign tx_take_o = tx_take_q;
endmodule
`default_nettype wire

// ---- thc_sva.sv ----
/*
 Port checker for the transmit HDLC controller.
 Assumes it is bound to thc_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module thc_sva
	import thc_pkg::*;
(
	// Clock, reset and APB
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	// Line side
	input wire thc_slot_t slot_i,
	input wire logic tx_bit_o,
	input wire logic tx_take_o
);
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!resetn_i);
	logic map_q;
	logic en_q;
	logic [7:0] sup_q;
	logic boc_q;
	logic t1_q;
	wire logic [9:0] idx = paddr_i[11:2];
	wire logic wr = psel_i && penable_i && pready_o && pwrite_i;
	wire logic hit = idx inside {THC_IDX_CTRL1, THC_IDX_SUPP, THC_IDX_CTRL2,
		THC_IDX_FIFO, THC_IDX_AUX, THC_IDX_STAT};
	// Mirror of written controls
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			map_q <= 1'b0;
			en_q <= 1'b0;
			sup_q <= 8'h00;
			boc_q <= 1'b0;
			t1_q <= 1'b0;
		end else if (wr) begin
			if (idx == THC_IDX_CTRL1)
				map_q <= pwdata_i[THC_C1_MAP];
			if (idx == THC_IDX_CTRL2) begin
				en_q <= pwdata_i[THC_C2_EN];
				boc_q <= pwdata_i[THC_C2_BOC];
			end
			if (idx == THC_IDX_AUX)
				t1_q <= pwdata_i[THC_AUX_T1];
			if (idx == THC_IDX_SUPP)
				sup_q <= pwdata_i[7:0];
		end
	end
	AST_TAKE_CAUSE: assert property (tx_take_o |-> $past(slot_i.strobe))
		else $error("take without a slot strobe");
	AST_DISABLED: assert property (slot_i.strobe && !en_q |=> !tx_take_o)
		else $error("slot used while disabled");
	AST_SUPPRESS: assert property (slot_i.strobe && !map_q && !slot_i.fdl
		&& sup_q[slot_i.pos] |=> !tx_take_o) else $error("suppressed position used");
	AST_FDL_ONLY: assert property (slot_i.strobe && map_q && !slot_i.fdl |=> !tx_take_o)
		else $error("channel slot used in bit-slot mapping");
	AST_SRST_QUIET: assert property (wr && idx == THC_IDX_CTRL1 && pwdata_i[THC_C1_SRST]
		|-> ##2 !tx_take_o [*7]) else $error("slot used during soft reset");
	AST_BIT_HOLD: assert property (!tx_take_o |-> $stable(tx_bit_o))
		else $error("line bit moved without a take");
	AST_PREADY_PULSE: assert property (pready_o |=> !pready_o)
		else $error("pready longer than one cycle");
	AST_PREADY_TIME: assert property (psel_i && $rose(penable_i) && idx != THC_IDX_FIFO
		|=> pready_o) else $error("register access not answered in time");
	AST_SLVERR: assert property (pready_o |-> pslverr_o == !hit)
		else $error("error response does not match decode");
	AST_BOC_SLOT: assert property (slot_i.strobe && slot_i.fdl && boc_q && t1_q && en_q
		|=> tx_take_o) else $error("code slot not used");
	cover property (wr && idx == THC_IDX_FIFO);
	cover property (tx_take_o && boc_q && t1_q);
	cover property (pready_o && pslverr_o);
	cover property (slot_i.strobe && !map_q && sup_q[slot_i.pos] && !slot_i.fdl);
endmodule
bind thc_top thc_sva u_sva (.sys_clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
	.pwdata_i, .prdata_o, .pready_o, .pslverr_o, .slot_i, .tx_bit_o, .tx_take_o);
`default_nettype wire

// ---- thc_far_end.sv ----
/*
 Remote HDLC receiver: finds flags, removes stuffed zeros, collects frames.
 Assumes one line bit per take pulse, least significant bit first.
*/
`timescale 1ns/1ps
`default_nettype none
module thc_far_end (
	// Line side
	input wire logic clk_i,
	input wire logic bit_i,
	input wire logic take_i
);
	logic q[$];
	logic [7:0] sh = 8'h00;
	logic [7:0] b;
	logic [7:0] bytes[$];
	int run = 0;
	int nframes = 0;
	int aborts = 0;
	int gap = 0;
	int last_gap = 0;
	always @(posedge clk_i) begin
		if (take_i === 1'b1) begin
			sh = {bit_i, sh[7:1]};
			if (sh == 8'h7e) begin
				repeat (7) if (q.size() > 0) void'(q.pop_back());
				if (q.size() == 0)
					gap++;
				else begin
					while (q.size() >= 8) begin
						for (int j = 0; j < 8; j++) b[j] = q.pop_front();
						bytes.push_back(b);
					end
					q.delete();
					nframes++;
					last_gap = gap;
					gap = 0;
				end
			end else if (bit_i || run != 5) begin
				// Seven ones then zero ends a frame as abort
				if (!bit_i && run == 7)
					aborts++;
				q.push_back(bit_i);
				if (run >= 6)
					q.delete();
			end
			run = bit_i ? run + 1 : 0;
		end
	end
endmodule
`default_nettype wire

// ---- tb_top.sv ----
/*
 Testbench for thc_top: APB master, random slot source, frame model.
 Assumes the checker is bound from its own file.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import thc_pkg::*;
	logic sys_clk_i = 1'b0;
	logic resetn_i = 1'b0;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0;
	logic [31:0] prdata_o;
	logic pready_o;
	logic pslverr_o;
	thc_slot_t slot_i = '0;
	logic tx_bit_o;
	logic tx_take_o;
	logic fdl_mode = 1'b0;
	integer seed = 32'ha491;
	logic [31:0] r;
	logic [31:0] rd;
	logic er;
	logic [7:0] sv;
	logic [15:0] bw = 16'h0000;
	logic [7:0] exp_q[$];
	logic [7:0] fr[$];
	logic [9:0] ri[3] = '{THC_IDX_CTRL1, THC_IDX_SUPP, THC_IDX_CTRL2};
	int err_count = 0;
	int total_checks = 0;
	int cyc = 0;
	int k;
	int a;
	int nf;
	int n;
	thc_top dut (.sys_clk_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
		.pwdata_i, .prdata_o, .pready_o, .pslverr_o, .slot_i, .tx_bit_o, .tx_take_o);
	thc_far_end rx (.clk_i(sys_clk_i), .bit_i(tx_bit_o), .take_i(tx_take_o));
	always #2 sys_clk_i = ~sys_clk_i;
	// Used line bits in send order, oldest at bit 0
	always @(posedge sys_clk_i) begin
		if (tx_take_o === 1'b1) begin
			bw = {tx_bit_o, bw[15:1]};
		end
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge sys_clk_i) begin
		r = $random(seed);
		slot_i <= thc_slot_t'({r[0], fdl_mode & r[7], (r[3:1] == 3'h0) ? 5'h05 : 5'h03, r[6:4]});
		cyc++;
		if (cyc == 60000) begin
			err_count++;
			conclude();
		end
	end
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] wd);
		@(posedge sys_clk_i);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= {idx, 2'b00};
		pwdata_i <= {24'h0, wd};
		@(posedge sys_clk_i);
		penable_i <= 1'b1;
		// Wait states until pready is seen at a rising edge
		do begin
			@(posedge sys_clk_i);
		end while (pready_o !== 1'b1);
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic send(input int nb, input logic [7:0] c1);
		logic [15:0] c;
		c = 16'hffff;
		apb(1, THC_IDX_CTRL1, c1);
		for (int i = 0; i < nb; i++) begin
			sv = (i == 1) ? 8'hff : 8'($random(seed));
			exp_q.push_back(sv);
			for (int j = 0; j < 8; j++) c = (c >> 1) ^ ((c[0] ^ sv[j]) ? 16'h8408 : 16'h0);
			if (i == nb - 1) apb(1, THC_IDX_CTRL1, c1 | 8'h04);
			apb(1, THC_IDX_FIFO, sv);
		end
		if (!c1[0]) exp_q.push_back(~c[7:0]);
		if (!c1[0]) exp_q.push_back(~c[15:8]);
	endtask
	task automatic drain(input int want);
		for (k = 0; k < 20000 && rx.nframes < want; k++) @(posedge sys_clk_i);
		chk("frames", rx.nframes, want);
		while (exp_q.size() > 0) begin
			rd = (rx.bytes.size() > 0) ? rx.bytes.pop_front() : 32'h100;
			chk("byte", rd, exp_q.pop_front());
		end
	endtask
	initial begin
		repeat (16) @(posedge sys_clk_i);
		resetn_i <= 1'b1;
		foreach (ri[i]) begin
			apb(0, ri[i], 8'h00);
			chk("reset_value", rd, 32'h0);
		end
		apb(1, 10'h112, 8'h5a);
		chk("unmapped", er, 1'b1);
		apb(1, THC_IDX_CTRL2, 8'h23);
		a = rx.aborts;
		apb(1, THC_IDX_CTRL1, 8'h20);
		apb(0, THC_IDX_CTRL1, 8'h00);
		chk("srst_busy", rd[5], 1'b1);
		repeat (200) @(posedge sys_clk_i);
		apb(0, THC_IDX_CTRL1, 8'h00);
		chk("srst_clear", rd, 32'h0);
		chk("srst_abort", rx.aborts, a + 1);
		chk("fill_flag", rx.run < 8, 1'b1);
		$display("end soft reset");
		for (int m = 0; m < 4; m++) begin
			sv = 8'($random(seed)) & 8'hee;
			apb(1, THC_IDX_SUPP, sv);
			apb(0, THC_IDX_SUPP, 8'h00);
			chk("suppress", rd, {24'h0, sv});
			apb(1, THC_IDX_AUX, {m[0], 7'h00});
			fdl_mode <= m[0];
			nf = rx.nframes;
			send(5 + m, {3'h0, m[0], 3'h0, m[1]});
			drain(nf + 1);
		end
		$display("end modes");
		for (int m = 0; m < 2; m++) begin
			apb(1, THC_IDX_CTRL2, 8'h03);
			nf = rx.nframes;
			send(8, {m[0], 7'h00});
			send(8, {m[0], 7'h00});
			apb(0, THC_IDX_STAT, 8'h00);
			chk("level", rd[4:0], 5'h10);
			chk("frozen", rx.nframes, nf);
			apb(1, THC_IDX_CTRL2, 8'h23);
			drain(nf + 2);
			chk("gap", rx.last_gap, m);
		end
		$display("end flags");
		nf = rx.nframes;
		a = rx.aborts;
		send(12, 8'h00);
		exp_q.delete();
		repeat (30) @(posedge sys_clk_i);
		apb(1, THC_IDX_CTRL2, 8'ha3);
		repeat (300) @(posedge sys_clk_i);
		apb(0, THC_IDX_STAT, 8'h00);
		chk("abort_flush", rd[4:0], 5'h00);
		chk("abort_sent", rx.aborts, a + 1);
		chk("abort_drop", rx.nframes, nf);
		apb(1, THC_IDX_CTRL2, 8'h23);
		$display("end abort");
		nf = rx.nframes;
		send(3, 8'h40);
		fr = exp_q;
		for (k = 0; k < 5000 && rx.nframes < nf + 3; k++) @(posedge sys_clk_i);
		apb(1, THC_IDX_CTRL1, 8'h00);
		repeat (1200) @(posedge sys_clk_i);
		n = rx.nframes;
		chk("loop_repeat", n >= nf + 3, 1'b1);
		repeat (n - nf - 1) exp_q = {exp_q, fr};
		drain(n);
		repeat (400) @(posedge sys_clk_i);
		chk("loop_stop", rx.nframes, n);
		apb(1, THC_IDX_CTRL1, 8'h08);
		repeat (400) @(posedge sys_clk_i);
		chk("fill_idle", rx.run >= 8, 1'b1);
		$display("end loop and fill");
		// Without stuffing the far end strips a real zero and loses the byte
		nf = rx.nframes;
		n = rx.bytes.size();
		apb(1, THC_IDX_CTRL1, 8'h07);
		apb(1, THC_IDX_FIFO, 8'h1f);
		for (k = 0; k < 5000 && rx.nframes < nf + 1; k++) @(posedge sys_clk_i);
		chk("zsd_frame", rx.nframes, nf + 1);
		chk("zsd_unstuffed", rx.bytes.size(), n);
		$display("end stuffing defeat");
		sv = 8'($random(seed)) & 8'h3f;
		apb(1, THC_IDX_CTRL1, 8'h10);
		apb(1, THC_IDX_AUX, 8'h40 | sv);
		apb(1, THC_IDX_CTRL2, 8'h63);
		repeat (300) @(posedge sys_clk_i);
		a = 0;
		for (int i = 0; i < 16; i++) begin
			if (16'({bw, bw} >> i) == {8'hff, 1'b0, sv[5:0], 1'b0}) a = 1;
		end
		chk("code_pattern", a, 1);
		$display("end code");
		conclude();
	end
endmodule
`default_nettype wire
